//--- core/epm_top.sv
// PHY mode select, PHY reset and boot flash control for a gigabit board.
//
// Function
// - Flash chip select follows boot chip select.
// - Flash output and write enables follow bus.
// - Ports default to GMII after power-on.
// - PHY reset on hard reset or control bit.
// - Mode bit zero enables the PHY path; code enables it for the five patterns only.
// - Pattern 1,1,0,0,0,0 selects GMII routing.
// - Pattern 1,0,0,1,0,0 selects ten-bit routing.
// - Pattern 1,0,1,0,0,0 selects reduced GMII routing.
// - Pattern 1,0,0,0,1,0 selects reduced ten-bit routing.
// - Pattern 0,0,0,0,0,1 selects MII routing.
// - Gigabit clocks: PHY receive, MAC transmit.
// - Reduced modes use only twelve signals.
// - Ten-bit mode reuses GMII lines, carrier high.
// - Ten-bit modes serve gigabit speed only.
// - Status register shows MAC port PHY setup.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "epm_regs.svh"
module epm_top #(
  parameter int unsigned CLK_TIMEOUT_CYC = `EPM_CLK_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // Register port.
  input  wire logic [`EPM_ADDR_W-1:0]        reg_addr,
  input  wire logic [`EPM_DATA_W-1:0]        reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [`EPM_DATA_W-1:0]        reg_rdata,
  // Board hard reset and MAC port strap switches.
  input  wire logic                          hard_reset_in_n,
  input  wire logic [`EPM_STRAP_W-1:0]       mac_cfg_strap,
  // Local bus controls toward the boot flash.
  input  wire logic                          boot_chip_select_n,
  input  wire logic                          local_output_enable_n,
  input  wire logic                          local_write_enable_0_n,
  output logic                               flash_ce_n,
  output logic                               flash_oe_n,
  output logic                               flash_we_n,
  // PHY reset shared by all PHYs.
  output logic                               phy_reset_n,
  // MAC transmit side of each communication port.
  input  wire logic [`EPM_NUM_PORTS-1:0]     mac_gtx_clk,
  input  wire logic [`EPM_NUM_PORTS-1:0][7:0] mac_txd,
  input  wire logic [`EPM_NUM_PORTS-1:0]     mac_tx_en,
  input  wire logic [`EPM_NUM_PORTS-1:0]     mac_tx_er,
  // PHY transmit side of each communication port.
  output logic      [`EPM_NUM_PORTS-1:0]     phy_gtx_clk,
  output logic      [`EPM_NUM_PORTS-1:0][7:0] phy_txd,
  output logic      [`EPM_NUM_PORTS-1:0]     phy_tx_en,
  output logic      [`EPM_NUM_PORTS-1:0]     phy_tx_er,
  output logic      [`EPM_NUM_PORTS-1:0]     phy_path_en,
  // PHY receive side of each communication port.
  input  wire logic [`EPM_NUM_PORTS-1:0]     phy_rx_clk,
  input  wire logic [`EPM_NUM_PORTS-1:0][7:0] phy_rxd,
  input  wire logic [`EPM_NUM_PORTS-1:0]     phy_rx_dv,
  input  wire logic [`EPM_NUM_PORTS-1:0]     phy_rx_er,
  input  wire logic [`EPM_NUM_PORTS-1:0]     phy_crs,
  input  wire logic [`EPM_NUM_PORTS-1:0]     phy_col,
  // MAC receive side of each communication port.
  output logic      [`EPM_NUM_PORTS-1:0]     mac_rx_clk,
  output logic      [`EPM_NUM_PORTS-1:0][7:0] mac_rxd,
  output logic      [`EPM_NUM_PORTS-1:0]     mac_rx_dv,
  output logic      [`EPM_NUM_PORTS-1:0]     mac_rx_er,
  output logic      [`EPM_NUM_PORTS-1:0]     mac_crs,
  output logic      [`EPM_NUM_PORTS-1:0]     mac_col
);
  import epm_pkg::*;

  localparam int NP     = `EPM_NUM_PORTS;
  localparam int TX_W   = $bits(epm_tx_t);
  localparam int RX_W   = $bits(epm_rx_t);
  localparam int SYNC_W = NP * (TX_W + RX_W) + 4 + `EPM_STRAP_W;
  localparam logic [`EPM_IDLE_CNT_W-1:0] TIMEOUT =
    CLK_TIMEOUT_CYC[`EPM_IDLE_CNT_W-1:0];

  // Reset release chain: asserts at once, releases two edges later.
  logic [1:0] rst_chain_q;
  logic       rst_sys_n;

  // Synchroniser bundle, raw and cleaned.
  logic [SYNC_W-1:0]             sync_raw;
  logic [SYNC_W-1:0]             sync_out;
  epm_tx_t [NP-1:0]              tx_raw;
  epm_rx_t [NP-1:0]              rx_raw;
  epm_tx_t [NP-1:0]              tx_s;
  epm_rx_t [NP-1:0]              rx_s;
  logic                          hard_rst_s_n;
  logic [2:0]                    flash_s_n;
  logic [`EPM_STRAP_W-1:0]       strap_s;

  // Routed groups from the per-port muxes.
  epm_tx_t [NP-1:0]              tx_mux;
  epm_rx_t [NP-1:0]              rx_mux;
  epm_mode_t [NP-1:0]            mode_sel;
  logic [NP-1:0]                 path_mux;

  // Receive clock watchdog terms.
  logic [NP-1:0]                       clk_edge;
  logic [NP-1:0]                       clk_alive;
  logic [NP-1:0][`EPM_IDLE_CNT_W-1:0]  idle_nxt;

  // Register state.
  epm_state_t state_q;
  epm_state_t state_d;

  // Reset release: a constant enters under reset, never a port value.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_chain_q <= 2'b00;
    end else begin
      rst_chain_q <= {rst_chain_q[0], 1'b1};
    end
  end

  assign rst_sys_n = rst_chain_q[1];

  // Per-port packing, routing and clock watchdog.
  generate
    for (genvar g = 0; g < NP; g++) begin : g_port
      assign tx_raw[g].clk = mac_gtx_clk[g];
      assign tx_raw[g].er  = mac_tx_er[g];
      assign tx_raw[g].en  = mac_tx_en[g];
      assign tx_raw[g].d   = mac_txd[g];
      assign rx_raw[g].clk = phy_rx_clk[g];
      assign rx_raw[g].col = phy_col[g];
      assign rx_raw[g].crs = phy_crs[g];
      assign rx_raw[g].er  = phy_rx_er[g];
      assign rx_raw[g].dv  = phy_rx_dv[g];
      assign rx_raw[g].d   = phy_rxd[g];

      epm_port_mux u_mux (
        .mode_bits (state_q.mode[g][5:0]),
        .tx_in     (tx_s[g]),
        .rx_in     (rx_s[g]),
        .tx_out    (tx_mux[g]),
        .rx_out    (rx_mux[g]),
        .mode_sel  (mode_sel[g]),
        .path_en   (path_mux[g])
      );

      // The PHY receive clock is sampled; a long quiet spell means dead.
      assign clk_edge[g]  = rx_s[g].clk ^ state_q.clk_prev[g];
      assign clk_alive[g] = (state_q.idle_cnt[g] < TIMEOUT);
      assign idle_nxt[g]  = clk_edge[g] ? '0 :
        (clk_alive[g] ? state_q.idle_cnt[g] + 1'b1 : TIMEOUT);
    end
  endgenerate

  // Every pin input except the register port passes two flops before anything reads it.
  assign sync_raw = {tx_raw, rx_raw, hard_reset_in_n,
                     boot_chip_select_n, local_output_enable_n,
                     local_write_enable_0_n, mac_cfg_strap};

  epm_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk (clk_sys),
    .d   (sync_raw),
    .q   (sync_out)
  );

  assign {tx_s, rx_s, hard_rst_s_n, flash_s_n, strap_s} = sync_out;

  // Next state: bus access, strap capture, routing and resets.
  always_comb begin
    state_d = state_q;

    // Flash controls are buffered copies of the local bus lines.
    state_d.flash_n[2]   = flash_s_n[2];
    state_d.flash_n[1:0] = flash_s_n[1:0];

    // Straps are caught once, on the first cycle after reset release.
    if (!state_q.strap_done) begin
      state_d.strap      = strap_s;
      state_d.strap_done = 1'b1;
    end

    // Routed groups register here so the pins see clean flop outputs.
    state_d.tx       = tx_mux;
    state_d.rx       = rx_mux;
    state_d.path_en  = path_mux;
    state_d.clk_prev = {rx_s[1].clk, rx_s[0].clk};
    state_d.idle_cnt = idle_nxt;

    // PHYs stay in reset while the board reset or the control bit holds.
    state_d.phy_rst_n = hard_rst_s_n &
      ~state_q.brc[`EPM_BRC_PHY_RESET_BIT];

    // Register writes; the status register ignores writes.
    if (reg_wr) begin
      case (reg_addr)
        `EPM_OFS_BOARD_RESET: state_d.brc     = reg_wdata;
        `EPM_OFS_PORT1_MODE:  state_d.mode[0] = reg_wdata;
        `EPM_OFS_PORT2_MODE:  state_d.mode[1] = reg_wdata;
        default:              state_d.brc     = state_q.brc;
      endcase
    end

    // Read data stands only in the cycle after the strobe.
    state_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `EPM_OFS_MAC_CFG_STATUS: begin
          state_d.rdata = {clk_alive, state_q.strap};
        end
        `EPM_OFS_BOARD_RESET: state_d.rdata = state_q.brc;
        `EPM_OFS_PORT1_MODE:  state_d.rdata = state_q.mode[0];
        `EPM_OFS_PORT2_MODE:  state_d.rdata = state_q.mode[1];
        default:              state_d.rdata = '0;
      endcase
    end
  end

  // Single state register; modes wake as GMII with no software help.
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      state_q            <= '0;
      state_q.mode[0]    <= `EPM_PORT_MODE_RST;
      state_q.mode[1]    <= `EPM_PORT_MODE_RST;
      state_q.brc        <= `EPM_BOARD_RESET_RST;
      state_q.idle_cnt   <= {NP{TIMEOUT}};
      state_q.flash_n    <= 3'h7;
      state_q.phy_rst_n  <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Board side outputs.
  assign reg_rdata   = state_q.rdata;
  assign flash_ce_n  = state_q.flash_n[2];
  assign flash_oe_n  = state_q.flash_n[1];
  assign flash_we_n  = state_q.flash_n[0];
  assign phy_reset_n = state_q.phy_rst_n;
  assign phy_path_en = state_q.path_en;

  // Port side outputs, unpacked from the registered groups.
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      phy_gtx_clk[i] = state_q.tx[i].clk;
      phy_txd[i]     = state_q.tx[i].d;
      phy_tx_en[i]   = state_q.tx[i].en;
      phy_tx_er[i]   = state_q.tx[i].er;
      mac_rx_clk[i]  = state_q.rx[i].clk;
      mac_rxd[i]     = state_q.rx[i].d;
      mac_rx_dv[i]   = state_q.rx[i].dv;
      mac_rx_er[i]   = state_q.rx[i].er;
      mac_crs[i]     = state_q.rx[i].crs;
      mac_col[i]     = state_q.rx[i].col;
    end
  end
endmodule

//--- core/epm_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef EPM_REGS_SVH
`define EPM_REGS_SVH

// Register port geometry.
`define EPM_ADDR_W              4
`define EPM_DATA_W              8
`define EPM_NUM_PORTS           2

// Register offsets on the plain register port.
`define EPM_OFS_MAC_CFG_STATUS  4'h3
`define EPM_OFS_BOARD_RESET     4'h4
`define EPM_OFS_PORT1_MODE      4'h8
`define EPM_OFS_PORT2_MODE      4'h9

// Reset values: both ports come up as GMII with the path enabled.
`define EPM_PORT_MODE_RST       8'h03
`define EPM_BOARD_RESET_RST     8'h00

// Field positions.
`define EPM_BRC_PHY_RESET_BIT   7
`define EPM_STS_ALIVE_LSB       6
`define EPM_STRAP_W             6

// Mode bit patterns, bit 0 in the least significant place.
`define EPM_PAT_GMII            6'h03
`define EPM_PAT_TBI             6'h09
`define EPM_PAT_RGMII           6'h05
`define EPM_PAT_RTBI            6'h11
`define EPM_PAT_MII             6'h20

// Receive clock watchdog: a longest gap, rounded down to whole cycles.
`define EPM_SYS_CLK_MHZ         125
`define EPM_CLK_TIMEOUT_NS      2000
`define EPM_CLK_TIMEOUT_CYC     \
  ((`EPM_CLK_TIMEOUT_NS * `EPM_SYS_CLK_MHZ) / 1000)
`define EPM_IDLE_CNT_W          9

`endif

//--- core/epm_pkg.sv
// Types shared by the PHY mode select block.
package epm_pkg;

  `include "epm_regs.svh"

  // Decoded interface flavour of one communication port.
  typedef enum logic [2:0] {
    EPM_ISO   = 3'b000,
    EPM_GMII  = 3'b001,
    EPM_TBI   = 3'b010,
    EPM_RGMII = 3'b011,
    EPM_RTBI  = 3'b100,
    EPM_MII   = 3'b101
  } epm_mode_t;

  // Transmit group, MAC toward PHY.
  typedef struct packed {
    logic       clk;
    logic       er;
    logic       en;
    logic [7:0] d;
  } epm_tx_t;

  // Receive group, PHY toward MAC.
  typedef struct packed {
    logic       clk;
    logic       col;
    logic       crs;
    logic       er;
    logic       dv;
    logic [7:0] d;
  } epm_rx_t;

  // Complete state of the top module.
  typedef struct packed {
    logic [`EPM_NUM_PORTS-1:0][`EPM_DATA_W-1:0]     mode;
    logic [`EPM_DATA_W-1:0]                         brc;
    logic [`EPM_STRAP_W-1:0]                        strap;
    logic                                           strap_done;
    logic [`EPM_NUM_PORTS-1:0]                      clk_prev;
    logic [`EPM_NUM_PORTS-1:0][`EPM_IDLE_CNT_W-1:0] idle_cnt;
    logic [`EPM_DATA_W-1:0]                         rdata;
    epm_tx_t [`EPM_NUM_PORTS-1:0]                   tx;
    epm_rx_t [`EPM_NUM_PORTS-1:0]                   rx;
    logic [`EPM_NUM_PORTS-1:0]                      path_en;
    logic                                           phy_rst_n;
    logic [2:0]                                     flash_n;
  } epm_state_t;

endpackage

//--- core/epm_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module epm_sync #(
  parameter int W = 1
) (
  // Clock.
  input  wire logic         clk,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import epm_pkg::*;

  logic [1:0][W-1:0] stage_q;
  logic [1:0][W-1:0] stage_d;

  // The first stage feeds only the second; nothing else may look at it.
  always_comb begin
    stage_d = {stage_q[0], d};
  end

  // No reset here: the chain refills while reset is still held.
  always_ff @(posedge clk) begin
    stage_q <= stage_d;
  end

  assign q = stage_q[1];
endmodule

//--- core/epm_port_mux.sv
// Mode decode and signal routing for one communication port.
`timescale 1ns/1ps
`include "epm_regs.svh"
module epm_port_mux (
  // Mode bits 0 to 5 of the port's mode register.
  input  wire logic [5:0]         mode_bits,
  // Synchronised MAC transmit and PHY receive groups.
  input  epm_pkg::epm_tx_t        tx_in,
  input  epm_pkg::epm_rx_t        rx_in,
  // Routed groups and decoded mode.
  output epm_pkg::epm_tx_t        tx_out,
  output epm_pkg::epm_rx_t        rx_out,
  output epm_pkg::epm_mode_t      mode_sel,
  output logic                    path_en
);
  import epm_pkg::*;

  // Only exact patterns connect; anything else isolates the port.
  always_comb begin
    case (mode_bits)
      `EPM_PAT_GMII:  mode_sel = EPM_GMII;
      `EPM_PAT_TBI:   mode_sel = EPM_TBI;
      `EPM_PAT_RGMII: mode_sel = EPM_RGMII;
      `EPM_PAT_RTBI:  mode_sel = EPM_RTBI;
      `EPM_PAT_MII:   mode_sel = EPM_MII;
      default:        mode_sel = EPM_ISO;
    endcase
  end

  // Isolated paths drive zero on every line rather than a partial mix.
  always_comb begin
    tx_out  = '0;
    rx_out  = '0;
    path_en = (mode_sel != EPM_ISO);
    case (mode_sel)
      EPM_GMII: begin
        // Gigabit clocks: MAC sources the transmit clock, PHY the receive.
        tx_out = tx_in;
        rx_out = rx_in;
      end
      EPM_TBI: begin
        // Code bits 9 and 8 ride on the error and enable/valid lines.
        // Ten-bit coding is gigabit only, so its clock always passes.
        tx_out     = tx_in;
        rx_out     = rx_in;
        rx_out.crs = 1'b1;
        rx_out.col = 1'b0;
      end
      EPM_RGMII, EPM_RTBI: begin
        // Twelve lines: clock, control and a nibble each way.
        tx_out.clk      = tx_in.clk;
        tx_out.en       = tx_in.en;
        tx_out.d[3:0]   = tx_in.d[3:0];
        rx_out.clk      = rx_in.clk;
        rx_out.dv       = rx_in.dv;
        rx_out.d[3:0]   = rx_in.d[3:0];
      end
      EPM_MII: begin
        // The PHY clocks both directions, so no gigabit clock goes out.
        tx_out.en     = tx_in.en;
        tx_out.er     = tx_in.er;
        tx_out.d[3:0] = tx_in.d[3:0];
        rx_out        = rx_in;
        rx_out.d[7:4] = 4'h0;
      end
      default: begin
        tx_out = '0;
        rx_out = '0;
      end
    endcase
  end
endmodule

//--- testbench/epm_chk_sva.sv
// Port checks for the PHY mode select block.
`timescale 1ns/1ps
`include "epm_regs.svh"
module epm_chk #(
  parameter int unsigned CLK_TIMEOUT_CYC = 16
) (
  // Clock, reset and register port.
  input wire logic            clk_sys,
  input wire logic            rst_n,
  input wire logic [3:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  // Board reset and flash controls.
  input wire logic            hard_reset_in_n,
  input wire logic            boot_chip_select_n,
  input wire logic            local_output_enable_n,
  input wire logic            local_write_enable_0_n,
  input wire logic            flash_ce_n,
  input wire logic            flash_oe_n,
  input wire logic            flash_we_n,
  input wire logic            phy_reset_n,
  // Port data paths.
  input wire logic [1:0][7:0] mac_txd,
  input wire logic [1:0][7:0] phy_txd,
  input wire logic [1:0]      phy_gtx_clk,
  input wire logic [1:0]      phy_tx_er,
  input wire logic [1:0]      phy_path_en,
  input wire logic [1:0][7:0] phy_rxd,
  input wire logic [1:0][7:0] mac_rxd,
  input wire logic [1:0]      mac_crs,
  input wire logic [1:0]      mac_col
);
  logic [2:0] up_q;
  logic [7:0] m1_q;
  logic       ok;
  logic [5:0] m1;
  // Checks wait until the synchroniser pipeline holds no reset history.
  assign ok = (up_q == 3'h7);
  assign m1 = m1_q[5:0];
  // Settle counter and a shadow of the port 1 mode register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 3'h0;
      m1_q <= `EPM_PORT_MODE_RST;
    end else begin
      up_q <= ok ? up_q : up_q + 3'h1;
      if (reg_wr && reg_addr == `EPM_OFS_PORT1_MODE)
        m1_q <= reg_wdata;
    end
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_flash_select: assert property (
    ok |-> flash_ce_n == $past(boot_chip_select_n, 3))
    else $error("flash select does not follow boot select");
  chk_flash_strobes: assert property (
    ok |-> flash_oe_n == $past(local_output_enable_n, 3) &&
    flash_we_n == $past(local_write_enable_0_n, 3))
    else $error("flash strobes do not follow bus strobes");
  chk_phy_rst_hard: assert property (
    (ok && !hard_reset_in_n) [*5] |-> !phy_reset_n)
    else $error("hard reset does not reach the PHY reset");
  chk_phy_rst_cause: assert property (
    ok && phy_reset_n |->
    $past(hard_reset_in_n, 3) || $past(hard_reset_in_n, 4))
    else $error("PHY reset released during hard reset");
  chk_mode_readback: assert property (
    ok && reg_rd && reg_addr == `EPM_OFS_PORT1_MODE |=>
    reg_rdata == $past(m1_q))
    else $error("port 1 mode read back wrong");
  chk_path_enable: assert property (
    ok |-> phy_path_en[0] == ($past(m1) inside {`EPM_PAT_GMII,
    `EPM_PAT_TBI, `EPM_PAT_RGMII, `EPM_PAT_RTBI, `EPM_PAT_MII}))
    else $error("path enable disagrees with mode");
  chk_gmii_pass: assert property (
    ok && $past(m1) == `EPM_PAT_GMII |-> phy_txd[0] == $past(mac_txd[0], 3)
    && mac_rxd[0] == $past(phy_rxd[0], 3))
    else $error("wide mode data not passed");
  chk_tbi_carrier: assert property (
    ok && $past(m1) == `EPM_PAT_TBI |-> mac_crs[0] && !mac_col[0] &&
    phy_txd[0] == $past(mac_txd[0], 3))
    else $error("ten-bit mode carrier or data wrong");
  chk_reduced_nibble: assert property (
    ok && $past(m1) inside {`EPM_PAT_RGMII, `EPM_PAT_RTBI} |->
    phy_txd[0] == {4'h0, $past(mac_txd[0][3:0], 3)} &&
    mac_rxd[0][7:4] == 4'h0 && !phy_tx_er[0])
    else $error("reduced mode uses extra lines");
  chk_mii_route: assert property (
    ok && $past(m1) == `EPM_PAT_MII |-> !phy_gtx_clk[0] &&
    phy_txd[0][3:0] == $past(mac_txd[0][3:0], 3) && mac_rxd[0][7:4] == 4'h0)
    else $error("nibble mode routing wrong");
  chk_iso_quiet: assert property (
    ok && !phy_path_en[0] |->
    phy_txd[0] == 8'h00 && mac_rxd[0] == 8'h00 && !mac_crs[0])
    else $error("isolated port still drives");
  cov_tbi: cover property (ok && $past(m1) == `EPM_PAT_TBI);
  cov_iso: cover property (ok && !phy_path_en[0]);
  cov_hard: cover property (ok && !hard_reset_in_n && !phy_reset_n);
endmodule

//--- testbench/epm_phy_model.sv
// Behavioural model of the two PHYs on the communication ports.
`timescale 1ns/1ps
module epm_phy_model (
  // Board controls.
  input  wire logic      phy_reset_n,
  input  wire logic [3:0] hw_cfg_mode,
  // Receive groups toward the block.
  output logic [1:0]      rx_clk,
  output logic [1:0][7:0] rxd,
  output logic [1:0]      rx_dv,
  output logic [1:0]      rx_er,
  output logic [1:0]      crs,
  output logic [1:0]      col
);
  logic [15:0] pat;
  logic        gig;
  logic        mii;
  assign gig = (hw_cfg_mode == 4'hf);
  assign mii = (hw_cfg_mode == 4'hb) && !gig;
  // Free-running receive clocks, offset so no edge meets the system clock.
  initial begin
    pat = 16'h1f3a;
    rx_clk = 2'b01;
    #3;
    forever #80 rx_clk = ~rx_clk;
  end
  // New data on every receive clock edge; a PHY in reset drives garbage that moves.
  // A soft reset over the management lines would look the same; those
  // lines are not modelled, so only the reset pin reaches this model.
  always @(posedge rx_clk[0] or negedge rx_clk[0]) begin
    pat = phy_reset_n ? {pat[14:0], pat[15] ^ pat[13] ^ pat[12] ^ pat[10]}
                      : ~pat;
    rxd[0] = pat[7:0];
    rxd[1] = {mii ? ~pat[11:8] : pat[15:12], pat[11:8]};
    rx_dv = pat[1:0];
    rx_er = pat[3:2];
    crs = pat[5:4];
    col = pat[9:8];
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the PHY mode select block.
`timescale 1ns/1ps
`include "epm_regs.svh"
module tb;
  import epm_pkg::*;
  localparam logic [3:0] P1 = `EPM_OFS_PORT1_MODE;
  localparam logic [3:0] P2 = `EPM_OFS_PORT2_MODE;
  localparam logic [3:0] BR = `EPM_OFS_BOARD_RESET;
  localparam logic [3:0] ST = `EPM_OFS_MAC_CFG_STATUS;
  // Five routed patterns, then three that must isolate the port.
  localparam logic [7:0] PATS [8] = '{8'h03, 8'h09, 8'h05, 8'h11, 8'h20,
                                     8'h02, 8'h07, 8'h3f};
  logic            clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]      reg_addr = 4'h0;
  logic [7:0]      reg_wdata = 8'h00, reg_rdata;
  logic            hard_reset_in_n = 1'b1, boot_chip_select_n = 1'b1;
  logic            local_output_enable_n = 1'b1, local_write_enable_0_n = 1'b1;
  logic [5:0]      mac_cfg_strap = 6'h00;
  logic            flash_ce_n, flash_oe_n, flash_we_n, phy_reset_n;
  logic [1:0]      mac_gtx_clk = 2'b00, mac_tx_en = 2'b00, mac_tx_er = 2'b00;
  logic [1:0][7:0] mac_txd = '0, phy_txd, phy_rxd, mac_rxd;
  logic [1:0]      phy_gtx_clk, phy_tx_en, phy_tx_er, phy_path_en, phy_rx_clk;
  logic [1:0]      phy_rx_dv, phy_rx_er, phy_crs, phy_col, mac_rx_clk;
  logic [1:0]      mac_rx_dv, mac_rx_er, mac_crs, mac_col;
  logic            rd_d = 1'b0;
  logic [3:0]      hw_cfg = 4'hf;
  logic [7:0]      exp_q [$];
  int              bad_count = 0, check_count = 0, cyc = 0;
  int              seed = 32'h7c09;

  epm_top #(.CLK_TIMEOUT_CYC(16)) dut_u (.*);
  epm_phy_model phy_u (.phy_reset_n(phy_reset_n), .hw_cfg_mode(hw_cfg),
    .rx_clk(phy_rx_clk), .rxd(phy_rxd), .rx_dv(phy_rx_dv),
    .rx_er(phy_rx_er), .crs(phy_crs), .col(phy_col));

  always #4 clk_sys = ~clk_sys;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; strobes stay up across back-to-back cycles.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk_sys);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Random MAC transmit traffic, plus the hang limit.
  always @(posedge clk_sys) begin
    mac_txd <= 16'($random(seed));
    {mac_gtx_clk, mac_tx_en, mac_tx_er} <= 6'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge clk_sys) begin
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end

  initial begin
    mac_cfg_strap = 6'($random(seed));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    idle(3);
    bus(0, P1, `EPM_PORT_MODE_RST);
    bus(0, P2, `EPM_PORT_MODE_RST);
    bus(0, BR, 8'h00);
    bus(0, 4'hf, 8'h00);
    idle(2);
    $display("defaults done");
    // Every pattern on both ports, each written then read with no gap.
    foreach (PATS[i]) begin
      hw_cfg <= (PATS[i] == 8'h20) ? 4'hb : 4'hf;
      bus(1, P1, PATS[i]);
      bus(1, P2, {2'b10, PATS[i][5:0]});
      bus(0, P1, PATS[i]);
      bus(0, P2, {2'b10, PATS[i][5:0]});
      idle(4);
      chk(phy_path_en, {6'h00, {2{i < 5}}});
      if (i == 1)
        chk(mac_crs[1], 8'h01);
      if (i == 2 || i == 3)
        chk(mac_rxd[1][7:4], 8'h00);
      if (i > 4) begin
        chk(mac_rxd[1], 8'h00);
        chk({phy_tx_en, mac_rx_dv, mac_rx_er, mac_rx_clk}, 8'h00);
      end
    end
    $display("modes done");
    // Status is read-only: a write there must change nothing.
    bus(0, ST, {2'b11, mac_cfg_strap});
    bus(1, ST, 8'hff);
    bus(0, ST, {2'b11, mac_cfg_strap});
    bus(1, BR, 8'h80);
    bus(0, BR, 8'h80);
    idle(5);
    chk(phy_reset_n, 8'h00);
    bus(1, BR, 8'h00);
    idle(6);
    chk(phy_reset_n, 8'h01);
    hard_reset_in_n <= 1'b0;
    idle(6);
    chk(phy_reset_n, 8'h00);
    hard_reset_in_n <= 1'b1;
    idle(6);
    chk(phy_reset_n, 8'h01);
    $display("phy reset done");
    for (int i = 0; i < 8; i++) begin
      {boot_chip_select_n, local_output_enable_n, local_write_enable_0_n}
        <= 3'(i);
      idle(4);
      chk({flash_ce_n, flash_oe_n, flash_we_n}, 8'(i));
    end
    $display("flash done");
    // A second reset must bring a reduced GMII port back to its default.
    bus(1, P1, 8'h05);
    idle(2);
    rst_n <= 1'b0;
    idle(3);
    rst_n <= 1'b1;
    idle(3);
    bus(0, P1, `EPM_PORT_MODE_RST);
    idle(3);
    $display("second reset done");
    give_verdict();
  end
endmodule

bind epm_top epm_chk #(.CLK_TIMEOUT_CYC(CLK_TIMEOUT_CYC)) chk_u (.*);
